// ### fcs_host_ctrl.sv
// Host controller that plays command sequences into the flash command port.
// Assumes the flash port shares clk_sys and returns read data one cycle
// after a read strobe, and software uses a simple strobe register port.
//
// Behaviour
// - Command writes are full words, code in low byte
// - Address bits one and zero always zero
// - Simple read: write 0xF0, then read
// - Two unlock writes open every long command
// - Read/reset: unlocks, 0xF0, then array read
// - Ident: unlocks, 0x90, write 0x00, then read
// - Page program: 0xA0 then four ascending words
// - Erase: 0x80, unlocks again, final code
// - Block erase keeps block upper bits throughout
// - Protect program: 0x9A thrice, last at bit address
// - New command only while device is ready; security rewrite and status read skip the ready poll
// - Never touch reserved control offsets
// - Security rewrite: key then data within 16
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module fcs_host_ctrl
    import fcs_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire fcs_pkg::fcs_sw_req_type sw_req,
    output fcs_pkg::fcs_dev_req_type dev_req,
    input  wire logic [31:0]     dev_rdata,
    output logic [31:0]          sw_rdata,
    output logic                 ctrl_busy
);
    import fcs_pkg::*;

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        fcs_state_type          state;
        fcs_op_type             op;
        logic [2:0]             idx;
        fcs_dev_req_type        dev;
        logic [31:0]            target;
        logic [DATA_WORDS-1:0][31:0] data;
        logic [2:0]             block_sel;
        logic [1:0]             ident_sel;
        logic                   sec_value;
        logic                   refused;
        logic                   busy;
        logic [31:0]            result;
        logic [31:0]            dev_status;
        logic [31:0]            sw_rdata;
    } fcs_regs_type;

    localparam fcs_regs_type REGS_RESET = '{state: S_IDLE, op: OP_READ, default: '0};
    localparam int SEC_WIN_MAX = 16;

    fcs_regs_type regs_reg;
    fcs_regs_type regs_next;
    fcs_step_type cur_step;
    fcs_op_type   req_op;
    logic         req_valid;

    // ****************************************************************
    // Sequence tables
    // ****************************************************************

    // Builds a write step
    function automatic fcs_step_type wr(input logic [31:0] a, input logic [31:0] d);
        fcs_step_type t;
        t.kind = K_WR;
        t.addr = a;
        t.data = d;
        return t;
    endfunction

    // Builds a read step
    function automatic fcs_step_type rd(input logic [31:0] a);
        fcs_step_type t;
        t.kind = K_RD;
        t.addr = a;
        t.data = '0;
        return t;
    endfunction

    // Third-cycle code of each unlocked command
    function automatic logic [7:0] code3(input fcs_op_type o);
        logic [7:0] c;
        case (o)
            OP_RDRST:  c = CODE_READ;
            OP_IDRD:   c = CODE_IDENT;
            OP_PAGE:   c = CODE_PAGE;
            OP_PPROG:  c = CODE_PROT_PROG;
            OP_PERASE: c = CODE_PROT_ERASE;
            default:   c = CODE_ERASE_PRE;
        endcase
        return c;
    endfunction

    // Bus cycle for the current op and step index
    function automatic fcs_step_type step_of(input fcs_regs_type s);
        fcs_step_type t;
        logic [31:0]  c54;
        logic [31:0]  ca;
        logic [31:0]  ia;
        logic [31:0]  pg;
        logic [31:0]  protect_bit_address;
        logic [31:0]  pers;
        logic [1:0]   widx;
        t    = '{kind: K_END, default: '0};
        c54  = {s.target[31:16], CMD_ADDR_HI, 8'h00};
        ca   = {s.target[31:16], UNLOCK2_NIB, 12'h000};
        ia   = {s.target[31:16], s.ident_sel, 14'h0000};
        widx = s.idx[1:0] - 2'd3;
        pg   = {s.target[31:4], widx, 2'b00};
        protect_bit_address  = {s.target[31:19], 1'b0, s.block_sel[2], 6'h00,
                s.block_sel[1:0], 9'h000};
        pers = {s.target[31:19], 1'b0, s.block_sel[2], 17'h00000};
        case (s.op)
            OP_READ:
            begin
                if (s.idx == 3'd0)
                    t = wr({s.target[31:2], 2'b00}, {24'h0, CODE_READ});
                else if (s.idx == 3'd1)
                    t = rd({s.target[31:2], 2'b00});
            end
            OP_SECW:
            begin
                if (s.idx == 3'd0)
                    t = wr(SEC_REG_ADDR, SEC_KEY);
                else if (s.idx == 3'd1)
                    t = wr(SEC_REG_ADDR, {31'h0, s.sec_value});
            end
            OP_STAT:
            begin
                if (s.idx == 3'd0)
                    t = rd(STAT_REG_ADDR);
            end
            default:
            begin
                case (s.idx)
                    3'd0: t = wr(c54, {24'h0, CODE_UNLOCK1});
                    3'd1: t = wr(ca, {24'h0, CODE_UNLOCK2});
                    3'd2: t = wr(c54, {24'h0, code3(s.op)});
                    3'd3:
                    begin
                        if (s.op == OP_RDRST)
                            t = rd({s.target[31:2], 2'b00});
                        else if (s.op == OP_IDRD)
                            t = wr(ia, {24'h0, CODE_IDENT_ARG});
                        else if (s.op == OP_PAGE)
                            t = wr(pg, s.data[widx]);
                        else
                            t = wr(c54, {24'h0, CODE_UNLOCK1});
                    end
                    3'd4:
                    begin
                        if (s.op == OP_IDRD)
                            t = rd({s.target[31:2], 2'b00});
                        else if (s.op == OP_PAGE)
                            t = wr(pg, s.data[widx]);
                        else if (s.op != OP_RDRST)
                            t = wr(ca, {24'h0, CODE_UNLOCK2});
                    end
                    3'd5:
                    begin
                        if (s.op == OP_PAGE)
                            t = wr(pg, s.data[widx]);
                        else if (s.op == OP_CHIP)
                            t = wr(c54, {24'h0, CODE_CHIP_ERASE});
                        else if (s.op == OP_BLOCK)
                            t = wr({s.target[31:2], 2'b00},
                                   {24'h0, CODE_BLK_ERASE});
                        else if (s.op == OP_PPROG || s.op == OP_PERASE)
                            t = wr(c54, {24'h0, code3(s.op)});
                    end
                    3'd6:
                    begin
                        if (s.op == OP_PAGE)
                            t = wr(pg, s.data[widx]);
                        else if (s.op == OP_PPROG)
                            t = wr(protect_bit_address, {24'h0, CODE_PROT_PROG});
                        else if (s.op == OP_PERASE)
                            t = wr(pers, {24'h0, CODE_PROT_ERASE});
                    end
                    default: t = '{kind: K_END, default: '0};
                endcase
            end
        endcase
        return t;
    endfunction

    // Ops that start an automatic operation in the device
    function automatic logic is_auto(input fcs_op_type o);
        return (o == OP_PAGE) || (o == OP_CHIP) || (o == OP_BLOCK)
            || (o == OP_PPROG) || (o == OP_PERASE);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Current step lookup and decode of the requested op
    assign cur_step  = step_of(regs_reg);
    assign req_op    = fcs_op_type'(sw_req.wdata[3:0]);
    assign req_valid = sw_req.wdata[3:0] <= OP_STAT;

    // Software port, sequencer and status poll
    always_comb
    begin
        regs_next           = regs_reg;
        regs_next.dev.write = 1'b0;
        regs_next.dev.read  = 1'b0;
        regs_next.sw_rdata  = '0;
        if (sw_req.write)
        begin
            case (sw_req.addr)
                SW_TARGET: regs_next.target = sw_req.wdata;
                SW_DATA0:  regs_next.data[0] = sw_req.wdata;
                SW_DATA1:  regs_next.data[1] = sw_req.wdata;
                SW_DATA2:  regs_next.data[2] = sw_req.wdata;
                SW_DATA3:  regs_next.data[3] = sw_req.wdata;
                SW_PARAM:
                begin
                    regs_next.block_sel = sw_req.wdata[PAR_BLK_LSB +: 3];
                    regs_next.ident_sel = sw_req.wdata[PAR_ID_LSB +: 2];
                    regs_next.sec_value = sw_req.wdata[PAR_SEC_BIT];
                end
                SW_STATUS:
                begin
                    if (sw_req.wdata[ST_REF_BIT])
                        regs_next.refused = 1'b0;
                end
                SW_CMD:
                begin
                    if (regs_reg.state == S_IDLE && req_valid)
                    begin
                        regs_next.op  = req_op;
                        regs_next.idx = 3'd0;
                        if (req_op == OP_SECW || req_op == OP_STAT)
                            regs_next.state = S_STEP;
                        else
                        begin
                            regs_next.state    = S_PRE_RD;
                            regs_next.dev.read = 1'b1;
                            regs_next.dev.addr = STAT_REG_ADDR;
                        end
                    end
                    else
                        regs_next.refused = 1'b1;
                end
                default: ;
            endcase
        end
        if (sw_req.read)
        begin
            case (sw_req.addr)
                SW_TARGET:  regs_next.sw_rdata = regs_reg.target;
                SW_DATA0:   regs_next.sw_rdata = regs_reg.data[0];
                SW_DATA1:   regs_next.sw_rdata = regs_reg.data[1];
                SW_DATA2:   regs_next.sw_rdata = regs_reg.data[2];
                SW_DATA3:   regs_next.sw_rdata = regs_reg.data[3];
                SW_PARAM:   regs_next.sw_rdata = {23'h0, regs_reg.sec_value, 2'b00,
                                                  regs_reg.ident_sel, 1'b0,
                                                  regs_reg.block_sel};
                SW_STATUS:  regs_next.sw_rdata = {30'h0, regs_reg.refused, regs_reg.busy};
                SW_RESULT:  regs_next.sw_rdata = regs_reg.result;
                SW_DEVSTAT: regs_next.sw_rdata = regs_reg.dev_status;
                default:    regs_next.sw_rdata = '0;
            endcase
        end
        case (regs_reg.state)
            S_IDLE: ;
            S_PRE_RD:   regs_next.state = S_PRE_CHK;
            S_PRE_CHK:
            begin
                regs_next.dev_status = dev_rdata;
                if (dev_rdata[READY_BIT])
                    regs_next.state = S_STEP;
                else
                begin
                    regs_next.state    = S_PRE_RD;
                    regs_next.dev.read = 1'b1;
                    regs_next.dev.addr = STAT_REG_ADDR;
                end
            end
            S_STEP:
            begin
                case (cur_step.kind)
                    K_WR:
                    begin
                        regs_next.dev.write = 1'b1;
                        regs_next.dev.addr  = cur_step.addr;
                        regs_next.dev.wdata = cur_step.data;
                        regs_next.idx       = regs_reg.idx + 3'd1;
                    end
                    K_RD:
                    begin
                        regs_next.dev.read = 1'b1;
                        regs_next.dev.addr = cur_step.addr;
                        regs_next.state    = S_RD_WAIT;
                    end
                    default:
                    begin
                        if (is_auto(regs_reg.op))
                        begin
                            regs_next.state    = S_POST_RD;
                            regs_next.dev.read = 1'b1;
                            regs_next.dev.addr = STAT_REG_ADDR;
                        end
                        else
                            regs_next.state = S_IDLE;
                    end
                endcase
            end
            S_RD_WAIT:  regs_next.state = S_RD_DATA;
            S_RD_DATA:
            begin
                regs_next.result = dev_rdata;
                regs_next.idx    = regs_reg.idx + 3'd1;
                regs_next.state  = S_STEP;
                if (regs_reg.op == OP_STAT)
                    regs_next.dev_status = dev_rdata;
            end
            S_POST_RD:  regs_next.state = S_POST_CHK;
            S_POST_CHK:
            begin
                regs_next.dev_status = dev_rdata;
                if (dev_rdata[READY_BIT])
                    regs_next.state = S_IDLE;
                else
                begin
                    regs_next.state    = S_POST_RD;
                    regs_next.dev.read = 1'b1;
                    regs_next.dev.addr = STAT_REG_ADDR;
                end
            end
            default:    regs_next.state = S_IDLE;
        endcase
        regs_next.busy = regs_next.state != S_IDLE;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            regs_reg <= REGS_RESET;
        else
            regs_reg <= regs_next;
    end

    // Outputs straight from the state record
    assign dev_req   = regs_reg.dev;
    assign sw_rdata  = regs_reg.sw_rdata;
    assign ctrl_busy = regs_reg.busy;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_addr_low_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        regs_reg.dev.write |-> regs_reg.dev.addr[1:0] == 2'b00)
        else $error("flash write with nonzero low address bits");

    a_code_low_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.dev.write && regs_reg.op != OP_PAGE && regs_reg.op != OP_SECW)
        |-> regs_reg.dev.wdata[31:8] == 24'h0)
        else $error("command write carries upper data bits");

    a_read_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.op == OP_READ && regs_reg.dev.write)
        |=> regs_reg.dev.read && !regs_reg.dev.write)
        else $error("simple read not followed by array read");

    a_unlock_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.dev.write && regs_reg.idx == 3'd1
         && regs_reg.op != OP_READ && regs_reg.op != OP_SECW)
        |-> regs_reg.dev.wdata[7:0] == CODE_UNLOCK1 && regs_reg.dev.addr[15:8] == CMD_ADDR_HI
            ##1 regs_reg.dev.write && regs_reg.dev.addr[15:12] == UNLOCK2_NIB)
        else $error("unlock pair malformed");

    a_page_ascend: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.op == OP_PAGE && regs_reg.dev.write && regs_reg.idx inside {3'd4, 3'd5, 3'd6})
        |=> regs_reg.dev.write && regs_reg.dev.addr == $past(regs_reg.dev.addr) + 32'h4)
        else $error("page words not in ascending order");

    a_block_upper: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.op == OP_BLOCK && regs_reg.dev.write)
        |-> regs_reg.dev.addr[31:16] == regs_reg.target[31:16])
        else $error("block erase cycle lost block upper bits");

    a_prot_last: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.op == OP_PPROG && regs_reg.dev.write && regs_reg.idx == 3'd7)
        |-> regs_reg.dev.wdata[7:0] == CODE_PROT_PROG && regs_reg.dev.addr[18] == 1'b0
            && regs_reg.dev.addr[16:11] == 6'h00)
        else $error("protect bit address write malformed");

    a_busy_repoll: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.state == S_PRE_CHK && !dev_rdata[READY_BIT])
        |=> regs_reg.dev.read && regs_reg.dev.addr == STAT_REG_ADDR && !regs_reg.dev.write)
        else $error("command sent while device busy");

    a_sec_window: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regs_reg.dev.write && regs_reg.dev.addr == SEC_REG_ADDR
         && regs_reg.dev.wdata == SEC_KEY)
        |-> ##[1:SEC_WIN_MAX] (regs_reg.dev.write && regs_reg.dev.addr == SEC_REG_ADDR))
        else $error("security data write missed the key window");

    a_refuse_sets: assert property (@(posedge clk_sys) disable iff (!rstn)
        (sw_req.write && sw_req.addr == SW_CMD && regs_reg.busy) |=> regs_reg.refused)
        else $error("command during busy not flagged");

endmodule // fcs_host_ctrl

// ### fcs_pkg.sv
// Constants, types and register map for the flash command sequencer host.
// Assumes one system clock shared with the flash command port it drives.
package fcs_pkg;

    // ****************************************************************
    // Device side: command codes and address fields
    // ****************************************************************
    localparam logic [7:0]  CODE_READ       = 8'hF0;
    localparam logic [7:0]  CODE_UNLOCK1    = 8'hAA;
    localparam logic [7:0]  CODE_UNLOCK2    = 8'h55;
    localparam logic [7:0]  CODE_IDENT      = 8'h90;
    localparam logic [7:0]  CODE_IDENT_ARG  = 8'h00;
    localparam logic [7:0]  CODE_PAGE       = 8'hA0;
    localparam logic [7:0]  CODE_ERASE_PRE  = 8'h80;
    localparam logic [7:0]  CODE_CHIP_ERASE = 8'h10;
    localparam logic [7:0]  CODE_BLK_ERASE  = 8'h30;
    localparam logic [7:0]  CODE_PROT_PROG  = 8'h9A;
    localparam logic [7:0]  CODE_PROT_ERASE = 8'h6A;
    localparam logic [7:0]  CMD_ADDR_HI     = 8'h54;
    localparam logic [3:0]  UNLOCK2_NIB     = 4'hA;
    localparam logic [31:0] SEC_KEY         = 32'hA74A9D23;
    localparam logic [31:0] CTRL_BASE       = 32'h41FFF000;
    localparam logic [31:0] SEC_REG_ADDR    = CTRL_BASE + 32'h00000010;
    localparam logic [31:0] STAT_REG_ADDR   = CTRL_BASE + 32'h00000020;
    localparam int          READY_BIT       = 0;
    localparam int          DATA_WORDS      = 4;

    // ****************************************************************
    // Host register map (software side)
    // ****************************************************************
    localparam logic [7:0]  SW_CMD      = 8'h00;
    localparam logic [7:0]  SW_TARGET   = 8'h04;
    localparam logic [7:0]  SW_DATA0    = 8'h08;
    localparam logic [7:0]  SW_DATA1    = 8'h0C;
    localparam logic [7:0]  SW_DATA2    = 8'h10;
    localparam logic [7:0]  SW_DATA3    = 8'h14;
    localparam logic [7:0]  SW_PARAM    = 8'h18;
    localparam logic [7:0]  SW_STATUS   = 8'h1C;
    localparam logic [7:0]  SW_RESULT   = 8'h20;
    localparam logic [7:0]  SW_DEVSTAT  = 8'h24;
    localparam int          PAR_BLK_LSB = 0;
    localparam int          PAR_ID_LSB  = 4;
    localparam int          PAR_SEC_BIT = 8;
    localparam int          ST_BUSY_BIT = 0;
    localparam int          ST_REF_BIT  = 1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [7:0] {
        S_IDLE     = 8'h01,
        S_PRE_RD   = 8'h02,
        S_PRE_CHK  = 8'h04,
        S_STEP     = 8'h08,
        S_RD_WAIT  = 8'h10,
        S_RD_DATA  = 8'h20,
        S_POST_RD  = 8'h40,
        S_POST_CHK = 8'h80
    } fcs_state_type;

    typedef enum logic [3:0] {
        OP_READ   = 4'h0,
        OP_RDRST  = 4'h1,
        OP_IDRD   = 4'h2,
        OP_PAGE   = 4'h3,
        OP_CHIP   = 4'h4,
        OP_BLOCK  = 4'h5,
        OP_PPROG  = 4'h6,
        OP_PERASE = 4'h7,
        OP_SECW   = 4'h8,
        OP_STAT   = 4'h9
    } fcs_op_type;

    typedef enum logic [1:0] {
        K_END = 2'h0,
        K_WR  = 2'h1,
        K_RD  = 2'h2
    } fcs_kind_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fcs_dev_req_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } fcs_sw_req_type;

    typedef struct packed {
        fcs_kind_type kind;
        logic [31:0]  addr;
        logic [31:0]  data;
    } fcs_step_type;

endpackage

// ### fcs_flash_model.sv
// Behavioural flash device that answers the host controller's flash port.
// Assumes fcs_pkg types and the shared system clock.
`timescale 1ns/1ns
module fcs_flash_model
    import fcs_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire fcs_pkg::fcs_dev_req_type dev_req,
    output logic [31:0]          dev_rdata
);
    logic [31:0] la [0:15];
    logic [31:0] ld [0:15];
    int          n;
    int          busy_cnt;
    logic        sec_bit;
    // Write log, erase timing, register replies
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            n = 0;
            busy_cnt <= 0;
            sec_bit <= 1'b1;
            dev_rdata <= 32'h0;
        end
        else
        begin
            dev_rdata <= ~dev_rdata; // Released data never holds
            if (busy_cnt > 0)
                busy_cnt <= busy_cnt - 1;
            if (dev_req.write)
            begin
                la[n[3:0]] = dev_req.addr;
                ld[n[3:0]] = dev_req.wdata;
                n++;
                if (busy_cnt == 0 && dev_req.wdata[7:0] == CODE_BLK_ERASE
                    && ld[4'(n - 2)][7:0] == CODE_UNLOCK2)
                    busy_cnt <= 9;
                if (dev_req.addr == SEC_REG_ADDR && dev_req.wdata != SEC_KEY)
                    sec_bit <= dev_req.wdata[0];
            end
            if (dev_req.read)
                dev_rdata <= (dev_req.addr == STAT_REG_ADDR) ?
                    {31'h0, busy_cnt == 0} : ~dev_req.addr;
        end
    end
endmodule // fcs_flash_model

// ### flash_command_sequencer_tb.sv
// Self-checking bench for the flash command sequencer host.
// Assumes fcs_host_ctrl and fcs_flash_model are compiled first.
`timescale 1ns/1ns
module flash_command_sequencer_tb
    import fcs_pkg::*;
;
    logic            clk_sys;
    logic            rstn;
    fcs_sw_req_type  sw_req;
    fcs_dev_req_type dev_req;
    logic [31:0]     dev_rdata;
    logic [31:0]     sw_rdata;
    logic            ctrl_busy;
    int              fails;
    int              checks;
    logic [31:0]     t;
    logic [15:0]     lo [0:4] = '{16'h5400, 16'hA000, 16'h5400, 16'h5400, 16'hA000};
    logic [7:0]      cd [0:4] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
    fcs_host_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .sw_req(sw_req),
        .dev_req(dev_req), .dev_rdata(dev_rdata), .sw_rdata(sw_rdata), .ctrl_busy(ctrl_busy));
    fcs_flash_model mdl (.clk_sys(clk_sys), .rstn(rstn), .dev_req(dev_req),
        .dev_rdata(dev_rdata));
    // Comparison, register access and command helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        sw_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        sw_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys);
        sw_req <= '0;
        #1 chk("sw_rdata", e, sw_rdata);
        @(posedge clk_sys);
    endtask
    task automatic run(input logic [31:0] op);
        mdl.n = 0;
        wr(SW_CMD, op);
        for (int i = 0; i < 300 && ctrl_busy !== 1'b0; i++)
            @(posedge clk_sys);
        chk("ctrl_busy", 32'h0, {31'h0, ctrl_busy});
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end
    // Main test sequence
    initial
    begin
        rstn = 1'b0;
        sw_req = '0;
        fails = 0;
        checks = 0;
        t = 32'h0004_0000; // Block 1 base
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(SW_STATUS, 32'h0);
        rd(8'h30, 32'h0);
        wr(SW_TARGET, t);
        mdl.busy_cnt <= 4; // Device busy on its own
        run(0);
        chk("read code", {24'h0, CODE_READ}, {24'h0, mdl.ld[0][7:0]});
        rd(SW_RESULT, ~t);
        run(5);
        chk("erase count", 32'd6, mdl.n);
        for (int i = 0; i < 5; i++)
        begin
            chk("erase addr", {t[31:16], lo[i]}, mdl.la[i]);
            chk("erase code", {24'h0, cd[i]}, {24'h0, mdl.ld[i][7:0]});
        end
        chk("block addr", t, mdl.la[5]);
        chk("block code", {24'h0, CODE_BLK_ERASE}, {24'h0, mdl.ld[5][7:0]});
        for (int i = 0; i < 4; i++)
            wr(SW_DATA0 + 8'(4 * i), 32'h1111_0000 * (i + 1) + 32'(i));
        run(3);
        chk("page code", {24'h0, CODE_PAGE}, {24'h0, mdl.ld[2][7:0]});
        for (int i = 0; i < 4; i++)
        begin
            chk("page addr", t + 32'(4 * i), mdl.la[3 + i]);
            chk("page word", 32'h1111_0000 * (i + 1) + 32'(i), mdl.ld[3 + i]);
        end
        wr(SW_PARAM, 32'h0);
        run(8);
        chk("key addr", SEC_REG_ADDR, mdl.la[0]);
        chk("key", SEC_KEY, mdl.ld[0]);
        chk("sec bit", 32'h0, {31'h0, mdl.sec_bit});
        wr(SW_PARAM, 32'h15);
        rd(SW_PARAM, 32'h15);
        run(2);
        chk("ident addr", {t[31:16], 2'b01, 14'h0}, mdl.la[3]);
        chk("ident arg", {24'h0, CODE_IDENT_ARG}, mdl.ld[3]);
        rd(SW_RESULT, ~t);
        run(1);
        chk("rdrst code", {24'h0, CODE_READ}, {24'h0, mdl.ld[2][7:0]});
        rd(SW_RESULT, ~t);
        run(4);
        chk("chip addr", {t[31:16], 16'h5400}, mdl.la[5]);
        chk("chip code", {24'h0, CODE_CHIP_ERASE}, {24'h0, mdl.ld[5][7:0]});
        run(6);
        chk("prot addr", 32'h0002_0200, mdl.la[6]);
        chk("prot code", {24'h0, CODE_PROT_PROG}, {24'h0, mdl.ld[6][7:0]});
        run(7);
        chk("perase addr", 32'h0002_0000, mdl.la[6]);
        chk("perase code", {24'h0, CODE_PROT_ERASE}, {24'h0, mdl.ld[6][7:0]});
        mdl.n = 0;
        wr(SW_CMD, 5);
        wr(SW_CMD, 5);
        rd(SW_STATUS, 32'h3);
        for (int i = 0; i < 300 && ctrl_busy !== 1'b0; i++)
            @(posedge clk_sys);
        run(9);
        rd(SW_RESULT, 32'h1);
        rd(SW_DEVSTAT, 32'h1);
        wr(SW_STATUS, 32'h2);
        rd(SW_STATUS, 32'h0);
        summarize();
    end
endmodule // flash_command_sequencer_tb
